/* File: dmx_pkg.sv */
// Purpose: Shared constants for the data-move execution block
// Assumes: 16-bit program words, 12-bit data addresses
// Notes:   Register offsets are word-aligned byte addresses
`default_nettype none
package dmx_pkg;
    // Opcode patterns, operand limits and special data addresses
    localparam logic [7:0]  OP_PTR_LOAD    = 8'hee;
    localparam logic [1:0]  OP_PTR_SUB     = 2'h0;
    localparam logic [5:0]  OP_SREG_MOVE   = 6'h14;
    localparam logic [3:0]  OP_FF_COPY     = 4'hc;
    localparam logic [3:0]  OP_SECOND_WORD = 4'hf;
    localparam logic [11:0] ADDR_ACC       = 12'hfe8;
    localparam logic [7:0]  INDEXED_LIMIT  = 8'h5f;
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
    localparam logic [11:0] ADDR_PC_LOW    = 12'hff9;
    localparam logic [11:0] ADDR_TOS_LO    = 12'hffd;
    localparam logic [11:0] ADDR_TOS_HI    = 12'hfff;
    // Wishbone register offsets
    localparam logic [5:0]  REG_INSTR      = 6'h00;
    localparam logic [5:0]  REG_CTRL       = 6'h04;
    localparam logic [5:0]  REG_ACC        = 6'h08;
    localparam logic [5:0]  REG_STATUS     = 6'h0c;
    localparam logic [5:0]  REG_PTR0       = 6'h10;
    localparam logic [5:0]  REG_PTR1       = 6'h14;
    localparam logic [5:0]  REG_PTR2       = 6'h18;
    localparam logic [5:0]  REG_MEM_ADDR   = 6'h1c;
    localparam logic [5:0]  REG_MEM_DATA   = 6'h20;
    // Control and status bit positions, bank reset value
    localparam int          CTRL_EXT_BIT   = 0;
    localparam int          ST_BUSY_BIT    = 0;
    localparam int          ST_ZERO_BIT    = 1;
    localparam int          ST_NEG_BIT     = 2;
    localparam int          ST_BADDST_BIT  = 3;
    localparam logic [3:0]  BANK_RESET     = 4'h0;
    // Quarter phases per instruction cycle
    localparam logic [1:0]  Q_READ         = 2'd1;
    localparam logic [1:0]  Q_WRITE        = 2'd3;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CYC1 = 4'b0010,
        ST_CYC2 = 4'b0100,
        ST_DONE = 4'b1000
    } dmx_state_type;
endpackage
`default_nettype wire

/* File: dmx_addr_unit.sv */
// Purpose: Forms a 12-bit data address from an 8-bit file operand
// Assumes: Bank select holds the upper address nibble
// Notes:   Indexed mode offsets from pointer 2
`default_nettype none
module dmx_addr_unit
    import dmx_pkg::*;
(
    input  wire logic [7:0]  file_i,
    input  wire logic        region_i,
    input  wire logic        ext_en_i,
    input  wire logic [3:0]  bank_i,
    input  wire logic [11:0] ptr2_i,
    output logic      [11:0] addr_o
);
    wire logic        indexed_w;
    wire logic [11:0] idx_w;
    wire logic [11:0] access_w;
    assign indexed_w = !region_i && ext_en_i && (file_i <= INDEXED_LIMIT);
    assign idx_w     = 12'(ptr2_i + {4'h0, file_i});
    assign access_w  = (file_i < ACCESS_SPLIT) ? {4'h0, file_i} : {ACCESS_HI_BANK, file_i};
    assign addr_o    = indexed_w ? idx_w : (region_i ? {bank_i, file_i} : access_w);
endmodule // dmx_addr_unit
`default_nettype wire

/* File: dmx_exec.sv */
// Purpose: Executes pointer load, single-register move and file copy
// Assumes: Software feeds program words through a Wishbone register
// Notes:   Data space is an internal 4096-byte array; accumulator at FE8h
//
// Operation
// - Pointer load puts 12-bit literal into chosen pointer, flags untouched.
// - Two-bit selector picks pointer; high nibble cycle one, low byte cycle two.
// - Pointer load and file copy take two words and two cycles.
// - Single move: one word, read Q2, write Q4, sets N and Z.
// - Region zero with extended set indexes operands up to 5Fh.
// - File copy moves byte unchanged, N and Z untouched; it sets or clears the bad-destination flag.
// - File copy addresses span 000h to FFFh, no banking.
// - Accumulator may be copy source or destination as a location.
// - Destination bit zero writes accumulator, one writes file register.
// - Region zero uses access window, one uses bank select.
//
// The Wishbone register port and the register offsets were left to the implementer.
`default_nettype none
module dmx_exec
    import dmx_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             busy_o
);
    logic [7:0]    mem_q [0:4095];
    dmx_state_type state_q;
    logic [1:0]    qph_q;
    logic [15:0]   word1_q;
    logic [15:0]   word2_q;
    logic          word2_ok_q;
    logic [11:0]   ptr_q [0:2];
    logic [3:0]    bank_q;
    logic          ext_en_q;
    logic          zero_q;
    logic          neg_q;
    logic          baddst_q;
    logic [7:0]    latch_q;
    logic [11:0]   mem_addr_q;
    logic          ack_q;

    wire logic        req_w;
    wire logic        wr_w;
    wire logic        rd_w;
    wire logic        is_ptr_w;
    wire logic        is_sreg_w;
    wire logic        is_ff_w;
    wire logic [1:0]  sel_w;
    wire logic [11:0] sreg_addr_w;
    wire logic [11:0] dst_w;
    wire logic [7:0]  acc_w;
    wire logic        instr_wr_w;
    wire logic [31:0] rd_mux_w;

    assign req_w      = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_w       = req_w && wb_we_i && wb_sel_i[0];
    assign rd_w       = req_w && !wb_we_i;
    assign instr_wr_w = wr_w && (wb_adr_i == REG_INSTR);
    assign is_ptr_w   = (word1_q[15:8] == OP_PTR_LOAD) && (word1_q[7:6] == OP_PTR_SUB)
                        && (word1_q[5:4] != 2'h3);
    assign is_sreg_w  = (word1_q[15:10] == OP_SREG_MOVE);
    assign is_ff_w    = (word1_q[15:12] == OP_FF_COPY);
    assign sel_w      = word1_q[5:4];
    assign acc_w      = mem_q[ADDR_ACC];
    assign dst_w      = word2_q[11:0];

    dmx_addr_unit u_addr (
        .file_i   (word1_q[7:0]),
        .region_i (word1_q[8]),
        .ext_en_i (ext_en_q),
        .bank_i   (bank_q),
        .ptr2_i   (ptr_q[2]),
        .addr_o   (sreg_addr_w)
    );

    // Reads return zero for unmapped offsets
    assign rd_mux_w = (wb_adr_i == REG_INSTR)    ? {word2_q, word1_q} :
                      (wb_adr_i == REG_CTRL)     ? {27'h0, bank_q, ext_en_q} :
                      (wb_adr_i == REG_ACC)      ? {24'h0, acc_w} :
                      (wb_adr_i == REG_STATUS)   ? {28'h0, baddst_q, neg_q, zero_q,
                                                    (state_q != ST_IDLE)} :
                      (wb_adr_i == REG_PTR0)     ? {20'h0, ptr_q[0]} :
                      (wb_adr_i == REG_PTR1)     ? {20'h0, ptr_q[1]} :
                      (wb_adr_i == REG_PTR2)     ? {20'h0, ptr_q[2]} :
                      (wb_adr_i == REG_MEM_ADDR) ? {20'h0, mem_addr_q} :
                      (wb_adr_i == REG_MEM_DATA) ? {24'h0, mem_q[mem_addr_q]} : 32'h0;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0;
            wb_ack_o <= 1'b0;
        end else begin
            ack_q    <= req_w;
            wb_ack_o <= req_w;
            wb_dat_o <= rd_w ? rd_mux_w : 32'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_en_q   <= 1'b0;
            bank_q     <= BANK_RESET;
            mem_addr_q <= 12'h0;
        end else if (wr_w && (wb_adr_i == REG_CTRL)) begin
            ext_en_q <= wb_dat_i[CTRL_EXT_BIT];
            bank_q   <= wb_dat_i[4:1];
        end else if (wr_w && (wb_adr_i == REG_MEM_ADDR)) begin
            mem_addr_q <= wb_dat_i[11:0];
        end
    end

    // Instruction words only load while idle; later writes are dropped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= ST_IDLE;
            qph_q      <= 2'd0;
            word1_q    <= 16'h0;
            word2_q    <= 16'h0;
            word2_ok_q <= 1'b0;
            zero_q     <= 1'b0;
            neg_q      <= 1'b0;
            baddst_q   <= 1'b0;
            latch_q    <= 8'h0;
            busy_o     <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                ptr_q[i] <= 12'h0;
            end
        end else begin
            qph_q <= (state_q == ST_IDLE) ? 2'd0 : 2'(qph_q + 2'd1);
            case (state_q)
                ST_IDLE: begin
                    if (instr_wr_w) begin
                        word1_q    <= wb_dat_i[15:0];
                        word2_q    <= wb_dat_i[31:16];
                        word2_ok_q <= (wb_dat_i[31:28] == OP_SECOND_WORD);
                        state_q    <= ST_CYC1;
                        busy_o     <= 1'b1;
                    end
                end
                ST_CYC1: begin
                    if (is_ptr_w && qph_q == Q_WRITE) begin
                        ptr_q[sel_w][11:8] <= word1_q[3:0];
                    end
                    if (is_sreg_w && qph_q == Q_READ) begin
                        latch_q <= mem_q[sreg_addr_w];
                    end
                    if (is_sreg_w && qph_q == Q_WRITE) begin
                        zero_q <= (latch_q == 8'h0);
                        neg_q  <= latch_q[7];
                    end
                    if (is_ff_w && qph_q == Q_READ) begin
                        latch_q <= mem_q[word1_q[11:0]];
                    end
                    if (qph_q == Q_WRITE) begin
                        state_q <= ((is_ptr_w || is_ff_w) && word2_ok_q) ? ST_CYC2 : ST_DONE;
                    end
                end
                ST_CYC2: begin
                    if (is_ptr_w && qph_q == Q_WRITE) begin
                        ptr_q[sel_w][7:0] <= word2_q[7:0];
                    end
                    if (is_ff_w && qph_q == Q_WRITE) begin
                        baddst_q <= (dst_w == ADDR_PC_LOW) || (dst_w >= ADDR_TOS_LO);
                    end
                    if (qph_q == Q_WRITE) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                    busy_o  <= 1'b0;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Memory has no reset; contents are software defined
    always_ff @(posedge clk_i) begin
        if (wr_w && (wb_adr_i == REG_MEM_DATA)) begin
            mem_q[mem_addr_q] <= wb_dat_i[7:0];
        end else if (state_q == ST_CYC1 && is_sreg_w && qph_q == Q_WRITE) begin
            if (word1_q[9]) begin
                mem_q[sreg_addr_w] <= latch_q;
            end else begin
                mem_q[ADDR_ACC] <= latch_q;
            end
        end else if (state_q == ST_CYC2 && is_ff_w && qph_q == Q_WRITE && !(
                     (dst_w == ADDR_PC_LOW) || (dst_w >= ADDR_TOS_LO))) begin
            mem_q[dst_w] <= latch_q;
        end
    end

    property p_two_cycle;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_CYC1 && qph_q == Q_WRITE && (is_ptr_w || is_ff_w) && word2_ok_q)
        |=> (state_q == ST_CYC2) [*4] ##1 (state_q == ST_DONE);
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("two-word op timing wrong");

    property p_one_cycle;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_CYC1 && qph_q == Q_WRITE && is_sreg_w) |=> (state_q == ST_DONE);
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("single move not one cycle");

    property p_zero_flag;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_CYC1 && qph_q == Q_WRITE && is_sreg_w)
        |=> (zero_q == ($past(latch_q) == 8'h0)) && (neg_q == $past(latch_q[7]));
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("move flags wrong");

    property p_ptr_flags;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_q != ST_IDLE && (is_ptr_w || is_ff_w)) |=> $stable(zero_q) && $stable(neg_q);
    endproperty
    a_ptr_flags: assert property (p_ptr_flags) else $error("flags moved");

    property p_ptr_low;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_CYC2 && qph_q == Q_WRITE && is_ptr_w)
        |=> (ptr_q[$past(sel_w)] == {$past(word1_q[3:0]), $past(word2_q[7:0])});
    endproperty
    a_ptr_low: assert property (p_ptr_low) else $error("pointer value wrong");

    property p_copy;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_CYC2 && qph_q == Q_WRITE && is_ff_w && !wr_w
         && dst_w < ADDR_PC_LOW) |=> (mem_q[$past(dst_w)] == $past(latch_q));
    endproperty
    a_copy: assert property (p_copy) else $error("copy data wrong");

    // Bus answers one cycle after request
    property p_ack;
        @(posedge clk_i) disable iff (!rst_n_i)
        req_w |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");

    // Busy spans at least four quarter phases plus the done clock
    property p_busy;
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_q == ST_IDLE && instr_wr_w) |=> busy_o ##4 busy_o;
    endproperty
    a_busy: assert property (p_busy) else $error("busy dropped early");
endmodule // dmx_exec
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench for the data-move execution block
// Assumes: One-cycle Wishbone ack; busy 5 or 9 clocks per instruction
// Notes:   Data array is not reset, so every read location is written first
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dmx_pkg::*;

    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [5:0]  wb_adr = 6'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0]  wb_sel = 4'h0;
    logic        wb_we = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        busy_o;
    int          errors = 0;
    int          total_checks = 0;
    logic [31:0] q;

    always #2 clk_i = ~clk_i;

    dmx_exec dmx_exec_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until ack is seen; data taken at that edge only
    task automatic xfer(input logic we, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic setmem(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, REG_MEM_ADDR, {20'h0, a});
        xfer(1'b1, REG_MEM_DATA, {24'h0, d});
    endtask

    task automatic getmem(input logic [11:0] a);
        xfer(1'b1, REG_MEM_ADDR, {20'h0, a});
        xfer(1'b0, REG_MEM_DATA, 32'h0);
    endtask

    // Busy clocks counted from the ack edge onward
    task automatic run(input logic [31:0] instr, input int clocks);
        int n;
        xfer(1'b1, REG_INSTR, instr);
        n = (busy_o === 1'b1) ? 1 : 0;
        while (busy_o === 1'b1 && n < 40) begin
            @(posedge clk_i);
            if (busy_o === 1'b1) n++;
        end
        check(32'(n), 32'(clocks));
    endtask

    task automatic test_reset();
        xfer(1'b0, REG_STATUS, 32'h0);
        check(q, 32'h0);
        xfer(1'b1, 6'h3c, 32'hffffffff);
        xfer(1'b0, 6'h3c, 32'h0);
        check(q, 32'h0);
        $display("test_reset done");
    endtask

    // One instruction cycle is four clocks, plus one done clock
    task automatic test_move();
        xfer(1'b1, REG_CTRL, 32'h4);
        xfer(1'b0, REG_CTRL, 32'h0);
        check(q, 32'h4);
        setmem(12'hf70, 8'h7f);
        run(32'h5070, 5);
        xfer(1'b0, REG_ACC, 32'h0);
        check({24'h0, q[7:0]}, 32'h7f);
        setmem(12'h245, 8'h80);
        run(32'h5145, 5);
        xfer(1'b0, REG_ACC, 32'h0);
        check({24'h0, q[7:0]}, 32'h80);
        xfer(1'b0, REG_STATUS, 32'h0);
        check({30'h0, q[2:1]}, 32'h2);
        setmem(12'h245, 8'h00);
        run(32'h5345, 5);
        getmem(12'h245);
        check({24'h0, q[7:0]}, 32'h0);
        xfer(1'b0, REG_ACC, 32'h0);
        check({24'h0, q[7:0]}, 32'h80);
        xfer(1'b0, REG_STATUS, 32'h0);
        check({30'h0, q[2:1]}, 32'h1);
        $display("test_move done");
    endtask

    task automatic test_ptr();
        logic [11:0] k [3] = '{12'hfff, 12'h000, 12'h3ab};
        for (int i = 0; i < 3; i++) begin
            run({16'hf000 | 16'(k[i][7:0]), 16'hee00 | 16'(i << 4) | 16'(k[i][11:8])}, 9);
            xfer(1'b0, REG_PTR0 + 6'(4 * i), 32'h0);
            check({20'h0, q[11:0]}, {20'h0, k[i]});
            xfer(1'b0, REG_STATUS, 32'h0);
            check({30'h0, q[2:1]}, 32'h1);
        end
        xfer(1'b0, REG_INSTR, 32'h0);
        check(q, 32'hf0abee23);
        $display("test_ptr done");
    endtask

    // Operands from 60h upward sit in the upper access window
    task automatic test_indexed();
        xfer(1'b1, REG_CTRL, 32'h1);
        setmem(12'h3bb, 8'h55);
        run(32'h5010, 5);
        xfer(1'b0, REG_ACC, 32'h0);
        check({24'h0, q[7:0]}, 32'h55);
        setmem(12'hf60, 8'h66);
        run(32'h5060, 5);
        xfer(1'b0, REG_ACC, 32'h0);
        check({24'h0, q[7:0]}, 32'h66);
        $display("test_indexed done");
    endtask

    task automatic test_copy();
        setmem(12'h000, 8'h33);
        run({16'hfabc, 16'hc000}, 9);
        getmem(12'habc);
        check({24'h0, q[7:0]}, 32'h33);
        xfer(1'b0, REG_STATUS, 32'h0);
        check({30'h0, q[2:1]}, 32'h0);
        run({16'hffe8, 16'hcabc}, 9);
        xfer(1'b0, REG_ACC, 32'h0);
        check({24'h0, q[7:0]}, 32'h33);
        setmem(12'hfff, 8'h12);
        run({16'hffff, 16'hcfe8}, 9);
        xfer(1'b0, REG_STATUS, 32'h0);
        check({31'h0, q[3]}, 32'h1);
        getmem(12'hfff);
        check({24'h0, q[7:0]}, 32'h12);
        $display("test_copy done");
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        test_reset();
        test_move();
        test_ptr();
        test_indexed();
        test_copy();
        test_done();
    end

    // Whole run needs well under 2000 clocks
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
